/* File: logic/pmd_cfg.svh */
/*
  constants of the peripheral module disable block: offsets, fields, reset values, timing.
  assumes a 125 MHz core clock and a 32-bit ahb-lite register bus.
*/
// Behaviour
// - after any reset all disable bits are clear, every peripheral enabled
// - disabled module gets no clock and no control inputs, performs nothing
// - disabled module held in reset, its register writes ignored, reads give zero
// - clearing a disable bit resumes the module from its power-on reset state
// - a re-enabled module may take up to one instruction cycle to become active
// - disabled module also has its pin-select routing disabled
// - system clock distribution bit stops the system clock to using peripherals only
// - control register 2: bits 7,6,5,2,1,0 read/write, reset 0, bits 4-3 read zero
`ifndef PMD_CFG_SVH
`define PMD_CFG_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define PMD_ADDR_W 8
`define PMD_OFS_CTRL0 8'h00
`define PMD_OFS_CTRL2 8'h08
`define PMD_OFS_ACTIVE 8'h0C

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define PMD_CTRL0_SYSCLK_BIT 0
`define PMD_CTRL2_MASK 8'hE7
`define PMD_CTRL0_RESET 1'h0
`define PMD_CTRL2_RESET 8'h00
`define PMD_UNITS 6

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PMD_CLK_PERIOD_NS 8
`define PMD_INSN_CYCLE_NS 32
`define PMD_WAKE_W 3
`define PMD_WAKE_CYCLES (`PMD_INSN_CYCLE_NS / `PMD_CLK_PERIOD_NS)

`endif

/* File: logic/pmd_pkg.sv */
/*
  types of the peripheral module disable block.
  assumes pmd_cfg.svh is found on the include path.
*/
`include "pmd_cfg.svh"

package pmd_pkg;

  // ----------------------------------------------------------------
  // per-module gate state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`PMD_WAKE_W-1:0] wake_cnt;
    logic clk_en;
    logic rst_hold;
    logic pps_en;
    logic access_en;
  } pmd_unit_state_t;

  // ----------------------------------------------------------------
  // register slave state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ctrl0;
    logic [7:0] ctrl2;
    logic wr_pend;
    logic [`PMD_ADDR_W-1:0] wr_addr;
    logic [31:0] rdata;
    logic sys_clk_en;
  } pmd_top_state_t;

endpackage

/* File: logic/pmd_unit_if.sv */
/*
  carrier between the disable register file and one module gate.
  assumes one instance per gated peripheral.
*/
`timescale 1ns/1ps

interface pmd_unit_if;
  logic disable_req;
  logic clk_en;
  logic rst_hold;
  logic pps_en;
  logic access_en;

  modport ctl (output disable_req, input clk_en, rst_hold, pps_en, access_en);
  modport unit (input disable_req, output clk_en, rst_hold, pps_en, access_en);
endinterface

/* File: logic/pmd_unit.sv */
/*
  gate for one peripheral: clock enable, reset hold, pin routing and register access.
  assumes disable_req comes from a flop on the same clock.
*/
`timescale 1ns/1ps
`include "pmd_cfg.svh"

module pmd_unit
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // gate
  pmd_unit_if.unit gate
);
  import pmd_pkg::*;

  pmd_unit_state_t st;
  pmd_unit_state_t next_st;

  // ----------------------------------------------------------------
  // gate logic
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.clk_en = !gate.disable_req;
    next_st.rst_hold = gate.disable_req;
    next_st.pps_en = !gate.disable_req;
    if (gate.disable_req)
    begin
      next_st.wake_cnt = `PMD_WAKE_W'(`PMD_WAKE_CYCLES);
    end
    else if (st.wake_cnt != '0)
    begin
      next_st.wake_cnt = st.wake_cnt - `PMD_WAKE_W'(1);
    end
    // access opens only once the wake count has run out
    next_st.access_en = !gate.disable_req && (st.wake_cnt == '0);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st <= '{wake_cnt: '0, clk_en: 1'b1, rst_hold: 1'b0, pps_en: 1'b1,
              access_en: 1'b1};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign gate.clk_en = st.clk_en;
  assign gate.rst_hold = st.rst_hold;
  assign gate.pps_en = st.pps_en;
  assign gate.access_en = st.access_en;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_release;
    $fell(gate.disable_req);
  endsequence

  a_gate_off: assert property (@(posedge hclk) disable iff (!hresetn)
    gate.disable_req |=> !gate.clk_en && gate.rst_hold)
    else $error("disabled module still clocked or out of reset");

  a_pps_off: assert property (@(posedge hclk) disable iff (!hresetn)
    gate.disable_req |=> !gate.pps_en)
    else $error("pin routing left on for a disabled module");

  a_no_access: assert property (@(posedge hclk) disable iff (!hresetn)
    gate.disable_req |=> !gate.access_en)
    else $error("register access allowed to a disabled module");

  a_resume_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    s_release |=> gate.clk_en && !gate.rst_hold)
    else $error("module not released from reset after enable");

  a_wake_delay: assert property (@(posedge hclk)
    disable iff (!hresetn || gate.disable_req)
    s_release |=> (!gate.access_en)[*4] ##1 gate.access_en)
    else $error("wake delay differs from one instruction cycle");

  a_reset_enabled: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> gate.clk_en && gate.access_en)
    else $error("module not enabled after reset");
endmodule

/* File: logic/pmd_top.sv */
/*
  peripheral module disable block: ahb-lite register slave and six module gates.
  assumes a single ahb-lite master; peripherals honour the gate outputs.
*/
`timescale 1ns/1ps
`include "pmd_cfg.svh"

module pmd_top
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // module gates: 5 calendar, 4 dac, 3 adc, 2 comparator two, 1 comparator one, 0 zero cross
  output logic [`PMD_UNITS-1:0] mod_clk_en,
  output logic [`PMD_UNITS-1:0] mod_rst_hold,
  output logic [`PMD_UNITS-1:0] mod_pps_en,
  output logic [`PMD_UNITS-1:0] mod_access_en,
  // system clock distribution
  output logic sys_clk_dist_en
);
  import pmd_pkg::*;

  pmd_top_state_t st;
  pmd_top_state_t next_st;
  logic take;
  logic [`PMD_UNITS-1:0] disable_vec;
  logic [`PMD_UNITS-1:0] access_vec;
  logic [`PMD_UNITS-1:0] clk_vec;
  logic [`PMD_UNITS-1:0] rst_vec;
  logic [`PMD_UNITS-1:0] pps_vec;

  // ----------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------
  // zero wait states: read data is built in the address phase so it can stand
  // in the data phase straight from a flop
  assign take = hsel && htrans[1] && hready;
  assign disable_vec = {st.ctrl2[7:5], st.ctrl2[2:0]};

  always_comb
  begin
    next_st = st;
    next_st.wr_pend = take && hwrite;
    next_st.wr_addr = haddr[`PMD_ADDR_W-1:0];
    if (take && !hwrite)
    begin
      // control registers are outside every gate, so always reachable
      case (haddr[`PMD_ADDR_W-1:0])
        `PMD_OFS_CTRL0:
        begin
          next_st.rdata = {31'h0000_0000, st.ctrl0};
        end
        `PMD_OFS_CTRL2:
        begin
          next_st.rdata = {24'h00_0000, st.ctrl2};
        end
        `PMD_OFS_ACTIVE:
        begin
          next_st.rdata = {26'h000_0000, access_vec};
        end
        default:
        begin
          next_st.rdata = 32'h0000_0000;
        end
      endcase
    end
    if (st.wr_pend)
    begin
      case (st.wr_addr)
        `PMD_OFS_CTRL0:
        begin
          next_st.ctrl0 = hwdata[`PMD_CTRL0_SYSCLK_BIT];
        end
        `PMD_OFS_CTRL2:
        begin
          next_st.ctrl2 = hwdata[7:0] & `PMD_CTRL2_MASK;
        end
        default:
        begin
          next_st.ctrl2 = st.ctrl2;
        end
      endcase
    end
    next_st.sys_clk_en = !st.ctrl0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st <= '{ctrl0: `PMD_CTRL0_RESET, ctrl2: `PMD_CTRL2_RESET, wr_pend: 1'b0,
              wr_addr: '0, rdata: 32'h0000_0000, sys_clk_en: 1'b1};
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // module gates
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `PMD_UNITS; gi++)
    begin : g_unit
      pmd_unit_if uif();
      assign uif.disable_req = disable_vec[gi];
      assign clk_vec[gi] = uif.clk_en;
      assign rst_vec[gi] = uif.rst_hold;
      assign pps_vec[gi] = uif.pps_en;
      assign access_vec[gi] = uif.access_en;
      pmd_unit u_unit
      (
        .hclk(hclk),
        .hresetn(hresetn),
        .gate(uif.unit)
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st.rdata;
  assign mod_clk_en = clk_vec;
  assign mod_rst_hold = rst_vec;
  assign mod_pps_en = pps_vec;
  assign mod_access_en = access_vec;
  assign sys_clk_dist_en = st.sys_clk_en;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_ctrl2_write;
    take && hwrite && (haddr[`PMD_ADDR_W-1:0] == `PMD_OFS_CTRL2);
  endsequence

  a_ctrl2_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
    (st.ctrl2 & ~`PMD_CTRL2_MASK) == 8'h00)
    else $error("reserved control bits became set");

  a_ctrl2_write: assert property (@(posedge hclk) disable iff (!hresetn)
    s_ctrl2_write ##1 1'b1 |=> st.ctrl2 == ($past(hwdata[7:0]) & `PMD_CTRL2_MASK))
    else $error("control register 2 write not stored");

  a_sysclk_follow: assert property (@(posedge hclk) disable iff (!hresetn)
    st.ctrl0 |=> !sys_clk_dist_en)
    else $error("system clock still distributed while cut");

  a_gate_map: assert property (@(posedge hclk) disable iff (!hresetn)
    st.ctrl2[7] |=> !mod_clk_en[5] && mod_rst_hold[5])
    else $error("calendar unit not gated by its disable bit");

  sequence s_ctrl0_write;
    take && hwrite && (haddr[`PMD_ADDR_W-1:0] == `PMD_OFS_CTRL0);
  endsequence

  sequence s_stray_write;
    take && hwrite && (haddr[`PMD_ADDR_W-1:0] != `PMD_OFS_CTRL0) &&
      (haddr[`PMD_ADDR_W-1:0] != `PMD_OFS_CTRL2);
  endsequence

  sequence s_stray_read;
    take && !hwrite && (haddr[`PMD_ADDR_W-1:0] != `PMD_OFS_CTRL0) &&
      (haddr[`PMD_ADDR_W-1:0] != `PMD_OFS_CTRL2) &&
      (haddr[`PMD_ADDR_W-1:0] != `PMD_OFS_ACTIVE);
  endsequence

  // the slave never stalls or errors, so software always reaches the controls
  a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("register bus stalled or answered with an error");

  a_ctrl0_write: assert property (@(posedge hclk) disable iff (!hresetn)
    s_ctrl0_write ##1 1'b1 |=> st.ctrl0 == $past(hwdata[`PMD_CTRL0_SYSCLK_BIT]))
    else $error("control register 0 write not stored");

  a_stray_write: assert property (@(posedge hclk) disable iff (!hresetn)
    s_stray_write ##1 1'b1 |=> $stable(st.ctrl0) && $stable(st.ctrl2))
    else $error("write to an unmapped offset changed a control register");

  a_read_ctrl2: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && (haddr[`PMD_ADDR_W-1:0] == `PMD_OFS_CTRL2)
    |=> hrdata == {24'h00_0000, $past(st.ctrl2)})
    else $error("control register 2 read back wrong");

  a_read_active: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && (haddr[`PMD_ADDR_W-1:0] == `PMD_OFS_ACTIVE)
    |=> hrdata == {26'h000_0000, $past(mod_access_en)})
    else $error("active status read back wrong");

  a_read_stray: assert property (@(posedge hclk) disable iff (!hresetn)
    s_stray_read |=> hrdata == 32'h0000_0000)
    else $error("unmapped offset did not read zero");

  a_sysclk_back: assert property (@(posedge hclk) disable iff (!hresetn)
    !st.ctrl0 |=> sys_clk_dist_en)
    else $error("system clock not restored after the cut bit cleared");

  a_reset_regs: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> (st.ctrl2 == `PMD_CTRL2_RESET) && (st.ctrl0 == `PMD_CTRL0_RESET))
    else $error("control registers not cleared by reset");

  // one pair of checks per unit against its own disable_vec bit, so a gate fault shows up on the unit itself
  generate
    for (gi = 0; gi < `PMD_UNITS; gi++)
    begin : g_check
      a_unit_off: assert property (@(posedge hclk) disable iff (!hresetn)
        disable_vec[gi] |=> !mod_pps_en[gi] && !mod_access_en[gi] && mod_rst_hold[gi])
        else $error("unit gate left open for a disabled module");
      a_unit_on: assert property (@(posedge hclk) disable iff (!hresetn)
        !disable_vec[gi] |=> mod_clk_en[gi] && mod_pps_en[gi] && !mod_rst_hold[gi])
        else $error("unit gate not reopened for an enabled module");
    end
  endgenerate
endmodule

/* File: verification/peripheral_module_disable_test.sv */
/*
  self-checking bench for pmd_top: ahb-lite register access, module gates, system clock bit.
  assumes hreadyout feeds hready directly and the logic/ include path holds pmd_cfg.svh.
*/
`timescale 1ns/1ps

module peripheral_module_disable_test;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [5:0] mod_clk_en;
  logic [5:0] mod_rst_hold;
  logic [5:0] mod_pps_en;
  logic [5:0] mod_access_en;
  logic sys_clk_dist_en;
  int bad_count = 0;
  int comparisons = 0;
  int m_c0 = 0;
  int m_c2 = 0;
  int n;
  logic [31:0] v;

  assign hready = hreadyout;
  always #4 hclk = ~hclk;

  pmd_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .mod_clk_en(mod_clk_en), .mod_rst_hold(mod_rst_hold),
    .mod_pps_en(mod_pps_en), .mod_access_en(mod_access_en), .sys_clk_dist_en(sys_clk_dist_en));

  // ----------------------------------------------------------------
  // model and compares
  // ----------------------------------------------------------------
  // bit order of the gate vectors differs from the register: bits 4-3 have no unit
  function automatic logic [5:0] dvec(input int c2);
    return {c2[7:5], c2[2:0]};
  endfunction

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
    begin
      $display("*** PASS ***");
    end
    else
    begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t register got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_gate(input logic [5:0] acc);
    logic [5:0] d;
    logic [24:0] exp;
    d = dvec(m_c2);
    exp = {~d, d, ~d, acc, (m_c0[0] == 1'b0)};
    comparisons++;
    if ({mod_clk_en, mod_rst_hold, mod_pps_en, mod_access_en, sys_clk_dist_en} !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t gates exp %h", $time, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // bus master
  // ----------------------------------------------------------------
  task automatic wait_ready();
    int k;
    k = 0;
    do
    begin
      @(posedge hclk);
      k++;
    end
    while (hready !== 1'b1 && k < 50);
    if (k >= 50)
    begin
      bad_count++;
      $display("MISMATCH t=%0t bus wait ran out", $time);
      report_and_stop();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    check_reg(r, e);
    check_reg({30'h0000_0000, hreadyout, hresp}, 32'h0000_0002);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h6aaf82bd));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    check_gate(6'h3f);
    rd_chk(8'h08, 32'h0000_0000);
    rd_chk(8'h00, 32'h0000_0000);
    rd_chk(8'h0c, 32'h0000_003f);
    // random disable patterns; only the six implemented bits may stick
    for (int i = 0; i < 10; i++)
    begin
      v = $urandom;
      wr(8'h08, v);
      m_c2 = v & 32'h0000_00e7;
      rd_chk(8'h08, m_c2);
      repeat (8) @(posedge hclk);
      #1;
      check_gate(~dvec(m_c2));
      rd_chk(8'h0c, {26'h000_0000, ~dvec(m_c2)});
    end
    // everything off: gates drop one edge after the write lands
    wr(8'h08, 32'hffff_ffff);
    m_c2 = 32'h0000_00e7;
    @(posedge hclk);
    #1;
    check_gate(6'h00);
    wr(8'h04, 32'h0000_00ff);
    rd_chk(8'h04, 32'h0000_0000);
    rd_chk(8'h08, 32'h0000_00e7);
    // everything back on: clocks at once, access only after the wake time
    wr(8'h08, 32'h0000_0000);
    m_c2 = 0;
    n = 0;
    do
    begin
      @(posedge hclk);
      #1;
      n++;
      if (n == 1)
      begin
        check_gate(6'h00);
      end
    end
    while (mod_access_en !== 6'h3f && n < 20);
    // one edge to reopen the gate, then four wake cycles of one instruction
    check_reg(32'(n), 32'h0000_0005);
    check_gate(6'h3f);
    // software keeps off a freshly enabled unit for an instruction
    repeat (4) @(posedge hclk);
    wr(8'h00, 32'h0000_0001);
    m_c0 = 1;
    @(posedge hclk);
    #1;
    check_gate(6'h3f);
    rd_chk(8'h00, 32'h0000_0001);
    wr(8'h00, 32'h0000_0000);
    m_c0 = 0;
    @(posedge hclk);
    #1;
    check_gate(6'h3f);
    // reset in mid-run with units and system clock off
    wr(8'h08, 32'h0000_00a5);
    wr(8'h00, 32'h0000_0001);
    @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    #1;
    m_c0 = 0;
    m_c2 = 0;
    check_gate(6'h3f);
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    check_gate(6'h3f);
    rd_chk(8'h08, 32'h0000_0000);
    rd_chk(8'h00, 32'h0000_0000);
    report_and_stop();
  end
endmodule
